// ---- dv/ddr3_link_monitor.sv ----
// Purpose: link timing checks between controller and DRAM ends
// Assumes: link pins sampled on aclk; tick is a seen ck rise
// Notes: counters saturate, counts are in link clock ticks except gap, which counts aclk cycles
`timescale 1ns/1ns
module ddr3_link_monitor import ddr3_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic reset_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr
);
  localparam int GAP_MAX = 10 * T_REFI_CYC;
  logic ck_q, tick, col, last_pre, in_sr;
  logic [3:0] cmd;
  logic [9:0] tk_col, tk_pre, odt_lo, xs_cnt, gap;
  function automatic logic [9:0] sat(input logic [9:0] x);
    return (x == 10'h3FF) ? x : x + 10'h1;
  endfunction
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign tick = ck && !ck_q;
  assign col = (cmd == CMD_RD) || (cmd == CMD_WR);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    ck_q <= aresetn ? ck : 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) tk_col <= 10'h3FF;
    else if (tick) tk_col <= col ? 10'h0 : sat(tk_col);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tk_pre <= 10'h0;
      last_pre <= 1'b0;
    end else if (tick && cmd != CMD_NOP) begin
      last_pre <= (cmd == CMD_PRE) && addr[A_AP];
      tk_pre <= (cmd == CMD_PRE) ? 10'h0 : sat(tk_pre);
    end else if (tick) begin
      tk_pre <= sat(tk_pre);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) odt_lo <= 10'h0;
    else if (tick) odt_lo <= odt ? 10'h0 : sat(odt_lo);
  end
  // Exit counter restarts when cke comes back after an entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sr <= 1'b0;
      xs_cnt <= 10'h3FF;
    end else if (in_sr && cke) begin
      in_sr <= 1'b0;
      xs_cnt <= 10'h0;
    end else if (tick) begin
      in_sr <= in_sr || (cmd == CMD_REF && !cke);
      xs_cnt <= sat(xs_cnt);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !cke || (tick && cmd == CMD_REF)) gap <= 10'h0;
    else gap <= sat(gap);
  end
  a_cmd_held: assert property (ck && ck_q
    |-> $stable({cmd, cke, ba, addr}))
    else $error("command changed while ck high");
  a_col_spacing: assert property (tick && col
    |-> tk_col >= T_CCD_CK - 1)
    else $error("column commands too close");
  a_ref_prea: assert property (tick && cmd == CMD_REF
    |-> last_pre && tk_pre >= PRE_WAIT_TK - 1)
    else $error("refresh without settled precharge all");
  a_sre_odt_off: assert property (tick && cmd == CMD_REF
    && !cke |-> odt_lo >= ODT_OFF_TK)
    else $error("odt not low long enough before entry");
  a_sr_cke_hold: assert property ($fell(cke)
    |-> !cke [*8])
    else $error("cke low too briefly");
  a_srx_nop: assert property (tick && cke
    && xs_cnt < T_XS_TK |-> cmd == CMD_NOP)
    else $error("command inside exit interval");
  a_xsdll_quiet: assert property (tick
    && xs_cnt < T_XSDLL_CK |-> !odt && !col && cmd != CMD_ZQ)
    else $error("odt or locked command before dll ready");
  a_ref_gap: assert property (gap < GAP_MAX)
    else $error("refresh gap too long");
  c_chop: cover property (tick && col && !addr[A_BC]);
  c_sre: cover property (tick && cmd == CMD_REF && !cke);
  c_srx: cover property (tick && xs_cnt == 10'h0);
endmodule

// ---- dv/ddr3_refresh_selfrefresh_burst_tb.sv ----
// Purpose: end to end bench for controller and DRAM ends
// Assumes: bench is the AXI4-Lite master
// Notes: device pulses are counted on the falling aclk edge
`timescale 1ns/1ns
module ddr3_refresh_selfrefresh_burst_tb import ddr3_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, sfault = 1'b0, doff = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, beats;
  logic [31:0] wdata = 32'h0, d, rdata;
  logic [1:0] r, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, col_cmd, col_wr, refp;
  logic idle, in_sr, dll_on, dll_rst, term, corrupt, apre;
  logic [2:0] bank;
  logic [10:0] cola;
  logic [15:0] row, k2;
  int num_errors = 0, samples_checked = 0, k;
  int cnt [5] = '{0, 0, 0, 0, 0};
  always #50 aclk = ~aclk;
  ddr3_link lk ();
  ddr3_ctrl_end ddr3_ctrl_end_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lk(lk));
  ddr3_dram_end ddr3_dram_end_inst (.aclk(aclk), .aresetn(aresetn), .lk(lk),
    .dll_off_mode(doff), .strobe_fault(sfault), .col_cmd_r(col_cmd),
    .col_write_r(col_wr), .col_bank_r(bank), .col_addr_r(cola),
    .burst_beats_r(beats), .auto_pre_r(apre), .refresh_pulse_r(refp),
    .refresh_row_r(row), .banks_idle_r(idle), .in_sr_r(in_sr),
    .dll_on_r(dll_on), .dll_reset_r(dll_rst), .term_on_r(term),
    .wr_corrupt_r(corrupt));
  ddr3_link_monitor ddr3_link_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .ck(lk.ck), .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n),
    .cas_n(lk.cas_n), .we_n(lk.we_n), .odt(lk.odt), .reset_n(lk.reset_n),
    .ba(lk.ba), .addr(lk.addr));
  always @(negedge aclk) begin
    if (col_cmd === 1'b1) cnt[0]++;
    if (refp === 1'b1) cnt[1]++;
    if (dll_rst === 1'b1) cnt[2]++;
    if (corrupt === 1'b1) cnt[3]++;
    if (in_sr === 1'b1) cnt[4]++;
  end
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: unexpected value", $time);
    end
  endtask
  task automatic tmo();
    num_errors++;
    $display("MISMATCH at %0t: wait timed out", $time);
    close_out();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) tmo();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) tmo();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_cnt(input int i, input int t);
    int n;
    for (n = 0; n < 6000 && cnt[i] < t; n++) @(negedge aclk);
    if (cnt[i] < t) tmo();
  endtask
  task automatic cmd(input int i, input logic [31:0] v);
    int n, c;
    c = cnt[i];
    wr(REG_CMD, v);
    chk(r === RESP_OKAY);
    wait_cnt(i, c + 1);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_CTRL);
    chk(d === 32'h1);
    rd(4'hC);
    chk(r === RESP_SLVERR && d === 32'h0);
    wr(REG_STATUS, 32'h0);
    chk(r === RESP_SLVERR);
    wr(REG_CTRL, 32'h0);
    cmd(0, {13'h0, 11'h7FF, 1'b0, 3'h5, 1'b1, OP_READ});
    chk(cola === 11'h7FF && bank === 3'h5 && beats === 4'h8 && !col_wr);
    chk(apre === 1'b0);
    cmd(0, {12'h0, 1'b1, 11'h555, 1'b0, 3'h2, 1'b0, OP_WRITE});
    chk(cola === 11'h555 && bank === 3'h2 && beats === 4'h4 && col_wr);
    chk(apre === 1'b1);
    k = cnt[3];
    sfault <= 1'b1;
    @(posedge aclk);
    sfault <= 1'b0;
    wait_cnt(3, k + 1);
    cmd(0, {13'h0, 11'h123, 1'b0, 3'h1, 1'b1, OP_READ});
    k = cnt[3];
    @(posedge aclk);
    sfault <= 1'b1;
    @(posedge aclk);
    sfault <= 1'b0;
    repeat (10) @(negedge aclk);
    chk(cnt[3] === k && cola === 11'h123);
    k2 = row;
    cmd(1, {29'h0, OP_REF});
    chk(row === k2 + 16'h1 && idle === 1'b1);
    k = cnt[1];
    repeat (1000) @(posedge aclk);
    rd(REG_STATUS);
    chk(cnt[1] > k && $signed(d[8:4]) <= 8);
    wr(REG_CTRL, 32'h3);
    // Termination shows only once the owed refreshes are paid back
    for (k = 0; k < 1000 && term !== 1'b1; k++) @(negedge aclk);
    chk(term === 1'b1);
    cmd(4, {29'h0, OP_SRE});
    chk(dll_on === 1'b0 && term === 1'b0);
    k = cnt[1];
    repeat (200) @(negedge aclk);
    chk(cnt[1] >= k + 2 && in_sr === 1'b1);
    wr(REG_CMD, {29'h0, OP_READ});
    chk(r === RESP_SLVERR);
    cmd(2, {29'h0, OP_SRX});
    rd(REG_STATUS);
    chk(d[F_DLLW] === 1'b1 && d[F_INSR] === 1'b0);
    cmd(0, {13'h0, 11'h0, 1'b0, 3'h7, 1'b1, OP_READ});
    chk(dll_on === 1'b1 && bank === 3'h7 && beats === 4'h8);
    doff <= 1'b1;
    repeat (3) @(negedge aclk);
    chk(dll_on === 1'b0);
    doff <= 1'b0;
    wr(REG_CMD, {29'h0, OP_ZQ});
    chk(r === RESP_OKAY);
    close_out();
  end
endmodule

// ---- rtl/ddr3_ctrl_end.sv ----
// Purpose: DDR3 controller end driven by AXI4-Lite command registers
// Assumes: one command pending at a time; link clock is aclk / CK_DIV
// Notes: commands change at link clock fall, sampled at its rise
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module ddr3_ctrl_end import ddr3_pkg::*; #(
  parameter int AXI_AW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ddr3_link.ctrl lk
);
  localparam int DIV_W = $clog2(CK_DIV);
  localparam int REFI_W = $clog2(T_REFI_CYC + 1);
  st_e st_r;
  op_e op;
  logic [DIV_W-1:0] div_r;
  logic tick, ck_r, ck_run_r, cke_r, odt_r, rst_n_r;
  logic [3:0] cmd4_r;
  logic [BA_W-1:0] ba_r;
  logic [ADDR_W-1:0] addr_r, col_a;
  logic [WAIT_W-1:0] wait_r, dll_wait_r;
  logic need_ref_r, tgt_sre_r, take_r, ref_pulse_r, sr_pulse_r, ref_due;
  logic pend_r, in_sr;
  logic [19:0] cmd_r;
  logic [1:0] ctrl_r;
  logic signed [DEBT_W-1:0] debt_r;
  logic [REFI_W-1:0] refi_r;
  logic aw_got_r, w_got_r, acc;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;

  assign lk.ck = ck_r;
  assign lk.cke = cke_r;
  assign {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} = cmd4_r;
  assign lk.odt = odt_r;
  assign lk.reset_n = rst_n_r;
  assign lk.ba = ba_r;
  assign lk.addr = addr_r;

  assign op = op_e'(cmd_r[F_OP +: 3]);
  assign in_sr = (st_r == ST_SR) || (st_r == ST_CKUP);
  assign tick = (div_r == DIV_W'(CK_DIV / 2 - 1));
  // Column word: bit 12 carries burst choice, bit 10 auto precharge
  assign col_a = {2'b00, cmd_r[F_BL8], cmd_r[F_COL + 10],
    cmd_r[F_AP], cmd_r[F_COL +: 10]};
  // Postponed debt, a requested refresh, entry with debt or an owed exit refresh, or auto mode with debt
  assign ref_due = (debt_r >= $signed(DEBT_W'(MAX_POSTPONE)))
    || (pend_r && op == OP_REF)
    || (pend_r && op == OP_SRE && (debt_r > 0 || need_ref_r))
    || (ctrl_r[F_AUTO] && !pend_r && debt_r > 0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= '0;
      ck_r <= 1'b0;
    end else begin
      div_r <= (div_r == DIV_W'(CK_DIV - 1)) ? '0 : div_r + 1'b1;
      if (div_r == DIV_W'(CK_DIV - 1)) begin
        ck_r <= ck_run_r;
      end else if (tick) begin
        ck_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      wait_r <= '0;
      dll_wait_r <= '0;
      cmd4_r <= CMD_NOP;
      cke_r <= 1'b0;
      odt_r <= 1'b0;
      rst_n_r <= 1'b0;
      ba_r <= '0;
      addr_r <= '0;
      ck_run_r <= 1'b1;
      need_ref_r <= 1'b0;
      tgt_sre_r <= 1'b0;
      take_r <= 1'b0;
      ref_pulse_r <= 1'b0;
      sr_pulse_r <= 1'b0;
    end else begin
      take_r <= 1'b0;
      ref_pulse_r <= 1'b0;
      sr_pulse_r <= 1'b0;
      if (tick) begin
        cmd4_r <= CMD_NOP;
        rst_n_r <= 1'b1;
        odt_r <= ctrl_r[F_ODT] && st_r == ST_IDLE
          && dll_wait_r == '0;
        if (wait_r != '0) wait_r <= wait_r - 1'b1;
        if (dll_wait_r != '0) dll_wait_r <= dll_wait_r - 1'b1;
        case (st_r)
          ST_IDLE: begin
            cke_r <= 1'b1;
            if (wait_r == '0) begin
              if (ref_due || (pend_r && op == OP_SRE)) begin
                cmd4_r <= CMD_PRE;
                addr_r <= '0;
                addr_r[A_AP] <= 1'b1;
                tgt_sre_r <= !ref_due;
                // Termination already off while the precharge is registered
                odt_r <= 1'b0;
                wait_r <= WAIT_W'(PRE_WAIT_TK - 1);
                st_r <= ST_PRE;
              end else if (pend_r) begin
                take_r <= 1'b1;
                ba_r <= cmd_r[F_BA +: BA_W];
                case (op)
                  OP_READ, OP_WRITE: begin
                    if (dll_wait_r == '0) begin
                      cmd4_r <= (op == OP_READ) ? CMD_RD : CMD_WR;
                      addr_r <= col_a;
                      wait_r <= WAIT_W'(T_CCD_CK - 1);
                    end else begin
                      take_r <= 1'b0;
                    end
                  end
                  OP_ACT: begin
                    cmd4_r <= CMD_ACT;
                    addr_r <= {4'h0, cmd_r[F_COL +: COL_W]};
                  end
                  OP_PREA: begin
                    cmd4_r <= CMD_PRE;
                    addr_r <= '0;
                    addr_r[A_AP] <= 1'b1;
                    wait_r <= WAIT_W'(T_RP_TK - 1);
                  end
                  OP_ZQ: begin
                    if (dll_wait_r == '0) begin
                      cmd4_r <= CMD_ZQ;
                      addr_r <= '0;
                      wait_r <= WAIT_W'(T_ZQCS_CK - 1);
                    end else begin
                      take_r <= 1'b0;
                    end
                  end
                  default: begin
                  end
                endcase
              end
            end
          end
          ST_PRE: begin
            if (wait_r == '0) begin
              cmd4_r <= CMD_REF;
              if (tgt_sre_r) begin
                cke_r <= 1'b0;
                sr_pulse_r <= 1'b1;
                take_r <= 1'b1;
                wait_r <= WAIT_W'(SR_HOLD_TK - 1);
                st_r <= ST_SR;
              end else begin
                ref_pulse_r <= 1'b1;
                need_ref_r <= 1'b0;
                take_r <= pend_r && op == OP_REF;
                wait_r <= WAIT_W'(T_RFC_TK - 1);
                st_r <= ST_IDLE;
              end
            end
          end
          ST_SR: begin
            cke_r <= 1'b0;
            if (wait_r == '0) begin
              ck_run_r <= 1'b0;
              if (pend_r && op == OP_SRX) begin
                ck_run_r <= 1'b1;
                wait_r <= WAIT_W'(T_CKSRX_TK - 1);
                st_r <= ST_CKUP;
              end
            end
          end
          ST_CKUP: begin
            if (wait_r == '0) begin
              cke_r <= 1'b1;
              take_r <= 1'b1;
              need_ref_r <= 1'b1;
              wait_r <= WAIT_W'(T_XS_TK - 1);
              dll_wait_r <= WAIT_W'(T_XSDLL_CK - 1);
              st_r <= ST_IDLE;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refi_r <= '0;
      debt_r <= '0;
    end else begin
      refi_r <= (in_sr || refi_r == REFI_W'(T_REFI_CYC - 1)) ? '0
        : refi_r + 1'b1;
      if (sr_pulse_r) begin
        debt_r <= '0;
      end else if (ref_pulse_r && refi_r != REFI_W'(T_REFI_CYC - 1)) begin
        if (debt_r > -$signed(DEBT_W'(MAX_PULLIN))) begin
          debt_r <= debt_r - 1'b1;
        end
      end else if (!ref_pulse_r && !in_sr
                   && refi_r == REFI_W'(T_REFI_CYC - 1)) begin
        debt_r <= debt_r + 1'b1;
      end
    end
  end

  assign acc = (awaddr_r[AXI_AW-1:2] == REG_CMD[AXI_AW-1:2]) && !pend_r
    && ((op_e'(wdata_r[F_OP +: 3]) == OP_SRX) == in_sr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      pend_r <= 1'b0;
      cmd_r <= '0;
      ctrl_r <= CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end else if (!w_got_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (take_r) pend_r <= 1'b0;
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_SLVERR;
        if (acc) begin
          cmd_r <= wdata_r[19:0];
          pend_r <= 1'b1;
          s_axi_bresp <= RESP_OKAY;
        end else if (awaddr_r[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
          ctrl_r <= wdata_r[1:0];
          s_axi_bresp <= RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_OKAY;
        if (s_axi_araddr[AXI_AW-1:2] == REG_CMD[AXI_AW-1:2]) begin
          s_axi_rdata[19:0] <= cmd_r;
        end else if (s_axi_araddr[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
          s_axi_rdata[1:0] <= ctrl_r;
        end else if (s_axi_araddr[AXI_AW-1:2]
                     == REG_STATUS[AXI_AW-1:2]) begin
          s_axi_rdata[F_PEND] <= pend_r;
          s_axi_rdata[F_INSR] <= in_sr;
          s_axi_rdata[F_DLLW] <= (dll_wait_r != '0);
          s_axi_rdata[F_NEEDREF] <= need_ref_r;
          s_axi_rdata[F_DEBT +: DEBT_W] <= debt_r;
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ---- rtl/ddr3_dram_end.sv ----
// Purpose: DRAM side command decode, refresh and self-refresh
// Assumes: controller keeps its own timing obligations
// Notes: all link pins pass two flops before use
`timescale 1ns/1ns
module ddr3_dram_end import ddr3_pkg::*; #(
  parameter int ROW_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  ddr3_link.dram lk,
  input wire logic dll_off_mode,
  input wire logic strobe_fault,
  output logic col_cmd_r,
  output logic col_write_r,
  output logic [BA_W-1:0] col_bank_r,
  output logic [COL_W-1:0] col_addr_r,
  output logic [3:0] burst_beats_r,
  output logic auto_pre_r,
  output logic refresh_pulse_r,
  output logic [ROW_W-1:0] refresh_row_r,
  output logic banks_idle_r,
  output logic in_sr_r,
  output logic dll_on_r,
  output logic dll_reset_r,
  output logic term_on_r,
  output logic wr_corrupt_r
);
  localparam int SW = 8 + BA_W + ADDR_W;
  localparam int SRC_W = $clog2(SR_REF_CYC + 1);
  logic [SW-1:0] raw, s;
  logic pin_rst_n, ck_s, cke_s, odt_s;
  logic [3:0] cmd4;
  logic [BA_W-1:0] ba_s;
  logic [ADDR_W-1:0] a_s;
  logic ck_q_r, rise, rst, cke_prev_r, dll_was_on_r, last_wr_r;
  logic [7:0] bank_open_r;
  logic [SRC_W-1:0] sr_cnt_r;

  assign raw = {lk.reset_n, lk.ck, lk.cke, lk.cs_n, lk.ras_n, lk.cas_n,
    lk.we_n, lk.odt, lk.ba, lk.addr};
  link_sync #(.W(SW)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(raw),
    .q(s)
  );
  assign {pin_rst_n, ck_s, cke_s, cmd4, odt_s, ba_s, a_s} = s;
  assign rst = !aresetn || !pin_rst_n;
  assign rise = ck_s && !ck_q_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_q_r <= 1'b0;
    end else begin
      ck_q_r <= ck_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      col_cmd_r <= 1'b0;
      col_write_r <= 1'b0;
      col_bank_r <= '0;
      col_addr_r <= '0;
      burst_beats_r <= 4'h8;
      auto_pre_r <= 1'b0;
      refresh_pulse_r <= 1'b0;
      refresh_row_r <= '0;
      in_sr_r <= 1'b0;
      dll_on_r <= 1'b0;
      dll_reset_r <= 1'b0;
      dll_was_on_r <= 1'b0;
      cke_prev_r <= 1'b0;
      bank_open_r <= 8'h00;
      sr_cnt_r <= '0;
      last_wr_r <= 1'b0;
      wr_corrupt_r <= 1'b0;
    end else begin
      col_cmd_r <= 1'b0;
      refresh_pulse_r <= 1'b0;
      dll_reset_r <= 1'b0;
      // Bad strobe timing only spoils the last write target
      wr_corrupt_r <= strobe_fault && last_wr_r;
      if (in_sr_r) begin
        // Own timer refreshes at once on entry, then periodically
        if (sr_cnt_r == '0) begin
          refresh_pulse_r <= 1'b1;
          refresh_row_r <= refresh_row_r + 1'b1;
        end
        if (sr_cnt_r == SRC_W'(SR_REF_CYC - 1)) begin
          sr_cnt_r <= '0;
        end else begin
          sr_cnt_r <= sr_cnt_r + 1'b1;
        end
        // Only CKE at a CK rise and reset_n are watched; every other control is ignored
        if (rise && cke_s) begin
          in_sr_r <= 1'b0;
          cke_prev_r <= 1'b1;
          dll_on_r <= dll_was_on_r;
          dll_reset_r <= dll_was_on_r;
        end
      end else begin
        dll_on_r <= !dll_off_mode;
        if (rise) begin
          cke_prev_r <= cke_s;
          if (cke_prev_r) begin
            case (cmd4)
              CMD_REF: begin
                if (cke_s) begin
                  // Row comes from the internal counter, not the pins
                  refresh_pulse_r <= 1'b1;
                  refresh_row_r <= refresh_row_r + 1'b1;
                  bank_open_r <= 8'h00;
                end else begin
                  in_sr_r <= 1'b1;
                  sr_cnt_r <= '0;
                  bank_open_r <= 8'h00;
                  dll_was_on_r <= !dll_off_mode;
                  dll_on_r <= 1'b0;
                end
              end
              CMD_ACT: begin
                bank_open_r[ba_s] <= 1'b1;
              end
              CMD_PRE: begin
                if (a_s[A_AP]) begin
                  bank_open_r <= 8'h00;
                end else begin
                  bank_open_r[ba_s] <= 1'b0;
                end
              end
              CMD_RD, CMD_WR: begin
                col_cmd_r <= 1'b1;
                col_write_r <= (cmd4 == CMD_WR);
                last_wr_r <= (cmd4 == CMD_WR);
                col_bank_r <= ba_s;
                // Bit 12 picks burst only and is kept out of the column
                col_addr_r <= {a_s[11], a_s[9:0]};
                burst_beats_r <= a_s[A_BC] ? 4'h8 : 4'h4;
                auto_pre_r <= a_s[A_AP];
              end
              default: begin
              end
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      banks_idle_r <= 1'b1;
      term_on_r <= 1'b0;
    end else begin
      banks_idle_r <= (bank_open_r == 8'h00);
      term_on_r <= odt_s && !in_sr_r;
    end
  end
endmodule

// ---- rtl/ddr3_link.sv ----
// Purpose: command and clock link between controller and DRAM ends
// Assumes: all signals driven by the controller end
// Notes: active-low command pins carry _n
`timescale 1ns/1ns
interface ddr3_link import ddr3_pkg::*;;
  logic ck;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic reset_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n,
    ba, addr);
  modport dram (input ck, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n,
    ba, addr);
endinterface

// ---- rtl/ddr3_pkg.sv ----
// Purpose: shared constants and types for the DDR3 command link ends
// Assumes: aclk at 10 MHz, link clock made by the controller divider
// Notes: times in ns, derived counts in link clock ticks or aclk cycles
package ddr3_pkg;
  localparam int CLK_NS = 100;
  localparam int CK_DIV = 8;
  localparam int CK_NS = CLK_NS * CK_DIV;
  localparam int T_RP_NS = 15;
  localparam int T_RFC_NS = 160;
  localparam int T_REFI_NS = 7800;
  localparam int T_XS_NS = 170;
  localparam int T_CKE_NS = 5;
  localparam int T_CKSRE_NS = 10;
  localparam int T_CKSRX_NS = 10;
  localparam int T_XSDLL_CK = 512;
  localparam int T_CCD_CK = 4;
  localparam int ODTL_CK = 3;
  localparam int T_ZQCS_CK = 64;
  localparam int T_RP_TK = (T_RP_NS + CK_NS - 1) / CK_NS;
  localparam int T_RFC_TK = (T_RFC_NS + CK_NS - 1) / CK_NS;
  localparam int T_XS_TK = (T_XS_NS + CK_NS - 1) / CK_NS;
  localparam int T_CKE_TK = (T_CKE_NS + CK_NS - 1) / CK_NS;
  localparam int T_CKSRE_TK = (T_CKSRE_NS + CK_NS - 1) / CK_NS;
  localparam int T_CKSRX_TK = (T_CKSRX_NS + CK_NS - 1) / CK_NS;
  localparam int ODT_OFF_TK = ODTL_CK + 1;
  localparam int PRE_WAIT_TK = (T_RP_TK > ODT_OFF_TK) ? T_RP_TK : ODT_OFF_TK;
  localparam int SR_HOLD_TK = (T_CKE_TK > T_CKSRE_TK) ? T_CKE_TK : T_CKSRE_TK;
  localparam int T_REFI_CYC = T_REFI_NS / CLK_NS;
  localparam int SR_REF_CYC = T_REFI_CYC;
  localparam int MAX_POSTPONE = 8;
  localparam int MAX_PULLIN = 8;
  localparam int WAIT_W = 10;
  localparam int DEBT_W = 5;
  localparam int ADDR_W = 15;
  localparam int BA_W = 3;
  localparam int COL_W = 11;
  localparam int A_AP = 10;
  localparam int A_BC = 12;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int F_OP = 0;
  localparam int F_BL8 = 3;
  localparam int F_BA = 4;
  localparam int F_COL = 8;
  localparam int F_AP = 19;
  localparam int F_AUTO = 0;
  localparam int F_ODT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int F_PEND = 0;
  localparam int F_INSR = 1;
  localparam int F_DLLW = 2;
  localparam int F_NEEDREF = 3;
  localparam int F_DEBT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_REF = 3'h2, OP_SRE = 3'h3,
    OP_SRX = 3'h4, OP_ZQ = 3'h5, OP_ACT = 3'h6, OP_PREA = 3'h7
  } op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_PRE = 2'h1, ST_SR = 2'h2, ST_CKUP = 2'h3
  } st_e;
endpackage

// ---- rtl/link_sync.sv ----
// Purpose: two-flop synchroniser for a bundle of link pins
// Assumes: bundle bits change only well away from the sampling point
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module link_sync #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
